// ===== logic/tpf_core.sv
// touch panel front end: serial link, sequencer, filter, pen detect
`timescale 1ns/1ps
`default_nettype none
module tpf_core (
    input  wire logic             clk_sys,
    input  wire logic             srst,
    input  wire logic             link_sclk,
    input  wire logic             spi_cs_n,
    input  wire logic             spi_sdi,
    output var  logic             spi_sdo,
    output var  logic             spi_sdo_oe_n,
    input  wire logic             pen_xplus_low,
    output var  logic             adc_start,
    input  wire logic             adc_done,
    input  wire logic [11:0]      adc_data,
    output var  tpf_pkg::tpf_ana_t ana,
    output var  logic             pen_touch_irq_n,
    output var  logic             result_invalid
);
    import tpf_pkg::*;

    // link side, frame state cleared when chip select goes high
    typedef struct packed {
        logic [3:0]  cnt;
        logic [6:0]  shin;
        logic        mode8;
        logic        conv_pend;
        logic [15:0] out;
    } tpf_frame_t;

    // link side events, cleared only by the system reset
    typedef struct packed {
        tpf_cmd_t    cmd;
        logic        cmd_tgl;
        logic        conv_tgl;
        logic        act_tgl;
        logic        res_s1;
        logic        res_s2;
        logic        res_seen;
        logic [11:0] res;
        logic        tim_s1;
        logic        tim_s2;
    } tpf_lev_t;

    // system side state
    typedef struct packed {
        logic [2:0]  cmd_s;
        logic [2:0]  conv_s;
        logic [2:0]  act_s;
        logic [1:0]  pen_s;
        tpf_state_t  state;
        tpf_cfg_t    cfg;
        tpf_cmd_t    cmd;
        logic        pen_en;
        logic [FILT_N-1:0][RES_W-1:0] smp;
        logic [2:0]  idx;
        logic [2:0]  pass;
        logic [11:0] res;
        logic        res_tgl;
        logic        irq_n;
        logic        invalid;
        logic        adc_start;
        tpf_ana_t    ana;
    } tpf_sys_t;

    tpf_frame_t fr_q, fr_d;
    tpf_lev_t   lv_q, lv_d;
    tpf_sys_t   sy_q, sy_d;
    logic       fr_rst;
    logic [7:0] byte_in;
    logic [13:0] mid_sum;

    assign fr_rst  = srst | spi_cs_n;
    assign byte_in = {fr_q.shin, spi_sdi};

    // frame counter, command shift-in and result shift-out
    always_comb
    begin
        fr_d = fr_q;
        fr_d.shin = byte_in[6:0];
        fr_d.out  = {fr_q.out[14:0], 1'b0};
        if (fr_q.cnt == (fr_q.mode8 ? FRAME_LAST_8 : FRAME_LAST_12))
            fr_d.cnt = 4'h0;
        else
            fr_d.cnt = fr_q.cnt + 4'h1;
        if (fr_q.cnt == CMD_BITS - 4'h1 && byte_in[7])
        begin
            if (byte_in[6:4] != CHAN_SETUP)
            begin
                fr_d.mode8     = byte_in[3];
                fr_d.conv_pend = 1'b1;
            end
            // adjusted timing puts the msb out before the next rise
            if (lv_q.tim_s2)
                fr_d.out = {lv_q.res, 4'h0};
            else
                fr_d.out = {1'b0, lv_q.res, 3'h0};
        end
        if (fr_q.cnt == CMD_BITS + ACQ_CLKS - 4'h1)
            fr_d.conv_pend = 1'b0;
    end

    // link events and crossings from the system side
    always_comb
    begin
        lv_d = lv_q;
        lv_d.res_s1 = sy_q.res_tgl;
        lv_d.res_s2 = lv_q.res_s1;
        lv_d.tim_s1 = sy_q.cfg.timing_adj;
        lv_d.tim_s2 = lv_q.tim_s1;
        if (lv_q.res_s2 != lv_q.res_seen)
        begin
            lv_d.res_seen = lv_q.res_s2;
            lv_d.res      = sy_q.res;   // stable since its toggle
        end
        if (fr_q.cnt == CMD_BITS - 4'h1 && byte_in[7])
        begin
            lv_d.cmd     = tpf_cmd_t'(byte_in);
            lv_d.cmd_tgl = ~lv_q.cmd_tgl;
        end
        if (fr_q.cnt == CMD_BITS + ACQ_CLKS - 4'h1 && fr_q.conv_pend)
            lv_d.conv_tgl = ~lv_q.conv_tgl;
        // any clock outside acquisition counts as host activity
        if (fr_q.cnt < CMD_BITS || fr_q.cnt >= CMD_BITS + ACQ_CLKS)
            lv_d.act_tgl = ~lv_q.act_tgl;
    end

    // frame state, dropped when chip select rises
    always_ff @(posedge link_sclk or posedge fr_rst)
    begin
        if (fr_rst)
        begin
            fr_q <= '0;
        end
        else
        begin
            fr_q <= fr_d;
        end
    end

    // event state, survives chip select
    always_ff @(posedge link_sclk or posedge srst)
    begin
        if (srst)
        begin
            lv_q <= '0;
        end
        else
        begin
            lv_q <= lv_d;
        end
    end

    // serial output changes on the falling edge
    always_ff @(negedge link_sclk or posedge fr_rst)
    begin
        if (fr_rst)
        begin
            spi_sdo      <= 1'b0;
            spi_sdo_oe_n <= 1'b1;
        end
        else
        begin
            spi_sdo      <= fr_q.out[15];
            spi_sdo_oe_n <= 1'b0;
        end
    end

    // switch settings for the selected channel
    function automatic tpf_ana_t drive(input tpf_cmd_t c);
        tpf_ana_t a;
        a = '0;
        a.chan = c.chan;
        case (c.chan)
            CHAN_Y:
            begin
                a.yp_drv = 1'b1;
                a.ym_drv = 1'b1;
            end
            CHAN_Z1, CHAN_Z2:
            begin
                a.xm_drv = 1'b1;
                a.yp_drv = 1'b1;
            end
            CHAN_X:
            begin
                a.xp_drv = 1'b1;
                a.xm_drv = 1'b1;
            end
            default:
            begin
                a.chan = c.chan;
            end
        endcase
        a.ref_diff = ~c.ref_single_diff_select & (a.yp_drv | a.xp_drv);
        return a;
    endfunction

    assign mid_sum = 14'(sy_q.smp[MID_LO]) + 14'(sy_q.smp[MID_LO + 1])
                   + 14'(sy_q.smp[MID_LO + 2]);

    // sequencer, filter and pen detect on the system clock
    always_comb
    begin
        sy_d = sy_q;
        sy_d.adc_start = 1'b0;
        sy_d.cmd_s  = {sy_q.cmd_s[1:0], lv_q.cmd_tgl};
        sy_d.conv_s = {sy_q.conv_s[1:0], lv_q.conv_tgl};
        sy_d.act_s  = {sy_q.act_s[1:0], lv_q.act_tgl};
        sy_d.pen_s  = {sy_q.pen_s[0], pen_xplus_low};
        case (sy_q.state)
            ST_IDLE:
            begin
                sy_d.irq_n = ~(sy_q.pen_en & sy_q.pen_s[1]);
            end
            ST_ACQ:
            begin
                if (sy_q.conv_s[2] != sy_q.conv_s[1])
                begin
                    sy_d.state = ST_CONV;
                    sy_d.idx   = 3'h0;
                end
            end
            ST_CONV:
            begin
                sy_d.adc_start = 1'b1;
                sy_d.state     = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (adc_done)
                begin
                    sy_d.smp[sy_q.idx] = adc_data;
                    if (sy_q.cfg.bypass)
                    begin
                        sy_d.res     = adc_data;
                        sy_d.res_tgl = ~sy_q.res_tgl;
                        sy_d.state   = ST_IDLE;
                        sy_d.irq_n   = 1'b1;
                        sy_d.pen_en  = ~sy_q.cmd.pd0;
                    end
                    else if (sy_q.idx == 3'(FILT_N - 1))
                    begin
                        sy_d.state = ST_SORT;
                        sy_d.pass  = 3'h0;
                    end
                    else
                    begin
                        sy_d.idx   = sy_q.idx + 3'h1;
                        sy_d.state = ST_CONV;
                    end
                end
            end
            ST_SORT:
            begin
                // odd-even transposition, one pass a cycle
                if (sy_q.pass == SORT_PASSES)
                begin
                    sy_d.res     = 12'(mid_sum / 14'd3);
                    sy_d.res_tgl = ~sy_q.res_tgl;
                    sy_d.state   = ST_IDLE;
                    sy_d.irq_n   = 1'b1;
                    sy_d.pen_en  = ~sy_q.cmd.pd0;
                end
                else
                begin
                    for (int i = int'(sy_q.pass[0]); i < FILT_N - 1;
                         i = i + 2)
                    begin
                        if (sy_q.smp[i] > sy_q.smp[i + 1])
                        begin
                            sy_d.smp[i]     = sy_q.smp[i + 1];
                            sy_d.smp[i + 1] = sy_q.smp[i];
                        end
                    end
                    sy_d.pass = sy_q.pass + 3'h1;
                end
            end
            default:
            begin
                sy_d.state = ST_IDLE;
            end
        endcase
        // host clocking before the end marks the result invalid
        if (sy_q.act_s[2] != sy_q.act_s[1] && (sy_q.state == ST_CONV ||
            sy_q.state == ST_WAIT || sy_q.state == ST_SORT))
        begin
            sy_d.state     = ST_IDLE;
            sy_d.adc_start = 1'b0;
            sy_d.irq_n     = 1'b1;
            sy_d.invalid   = 1'b1;
            sy_d.pen_en    = ~sy_q.cmd.pd0;
        end
        // a new conversion command restarts the sequence; a setup command writes the configuration
        if (sy_q.cmd_s[2] != sy_q.cmd_s[1])
        begin
            if (lv_q.cmd.chan == CHAN_SETUP)
            begin
                sy_d.cfg.pullup_90k = lv_q.cmd.mode8;
                sy_d.cfg.bypass     = lv_q.cmd.ref_single_diff_select;
                sy_d.cfg.timing_adj = lv_q.cmd.pd1;
                if (lv_q.cmd.pd0)
                begin
                    sy_d.cfg    = CFG_RESET;
                    sy_d.cmd    = CMD_RESET;
                    sy_d.state  = ST_IDLE;
                    sy_d.pen_en = 1'b1;
                    sy_d.irq_n  = 1'b1;
                end
            end
            else
            begin
                sy_d.cmd       = lv_q.cmd;
                sy_d.state     = ST_ACQ;
                sy_d.adc_start = 1'b0;
                sy_d.irq_n     = 1'b0;
                sy_d.invalid   = 1'b0;
                sy_d.pen_en    = 1'b0;
            end
        end
        // analog switches: armed, held on, or measuring
        if (sy_d.state == ST_IDLE && sy_d.pen_en)
        begin
            sy_d.ana = '0;
            sy_d.ana.ym_drv      = 1'b1;
            sy_d.ana.pen_connect = 1'b1;
        end
        else if (sy_d.state == ST_IDLE && !sy_d.cmd.pd0)
        begin
            sy_d.ana = '0;
        end
        else
        begin
            sy_d.ana = drive(sy_d.cmd);
            sy_d.ana.pen_connect = 1'b0;
        end
        sy_d.ana.pullup_90k = sy_d.cfg.pullup_90k;
    end

    // system state register
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sy_q        <= '0;
            sy_q.cfg    <= CFG_RESET;
            sy_q.cmd    <= CMD_RESET;
            sy_q.pen_en <= 1'b1;
            sy_q.irq_n  <= 1'b1;
        end
        else
        begin
            sy_q <= sy_d;
        end
    end

    // outputs straight from the state register
    assign adc_start       = sy_q.adc_start;
    assign ana             = sy_q.ana;
    assign pen_touch_irq_n = sy_q.irq_n;
    assign result_invalid  = sy_q.invalid;

endmodule
`default_nettype wire

// ===== logic/tpf_pkg.sv
// shared constants and carriers for the touch panel front end
//
// How it works
// - three serial clocks of acquisition per conversion
// - differential Y: references follow Y plus/minus
// - powerdown_select_lsb one keeps drivers on
// - pen pull-up selectable, small value default
// - setup bit three picks large pull-up
// - armed power-down: Y minus on, pen to X+
// - touch while armed pulls pen_touch_irq_n low
// - measurement isolates X+ from pen detect
// - lsb one disables pen detect until lsb zero
// - lsb zero re-arms pen detect at conversion end
// - filter: seven samples, sort, average middle three
// - filter on every channel, setup bypass allowed
// - serial clock idles low
// - both ends present first bit before edge
// - chip select may stay low between frames
// - full duplex: byte out while byte in
// - frames are sixteen or twelve clocks only
// - adjusted output timing for back-to-back reads
// - conversion runs on the internal clock
// - early serial clock ends conversion, result invalid
// - new command aborts running conversion
// - chip select high aborts reads, not conversions
// - start bit one, channel 010 is setup
// - mode bit: zero twelve bits, one eight
package tpf_pkg;

    localparam logic [2:0] CHAN_TEMP_SMALL = 3'h0;
    localparam logic [2:0] CHAN_Y          = 3'h1;
    localparam logic [2:0] CHAN_SETUP      = 3'h2;
    localparam logic [2:0] CHAN_Z1         = 3'h3;
    localparam logic [2:0] CHAN_Z2         = 3'h4;
    localparam logic [2:0] CHAN_X          = 3'h5;
    localparam logic [3:0] CMD_BITS        = 4'h8;
    localparam logic [3:0] ACQ_CLKS        = 4'h3;
    localparam logic [3:0] FRAME_LAST_12   = 4'hf;   // sixteen clocks
    localparam logic [3:0] FRAME_LAST_8    = 4'hb;   // twelve clocks
    localparam int         FILT_N          = 7;
    localparam int         MID_LO          = 2;
    localparam int         RES_W           = 12;
    localparam logic [2:0] SORT_PASSES     = 3'h7;

    // command byte, conversion view
    typedef struct packed {
        logic       start;
        logic [2:0] chan;
        logic       mode8;
        logic       ref_single_diff_select;
        logic       pd1;
        logic       pd0;
    } tpf_cmd_t;

    // static configuration written by the setup command
    typedef struct packed {
        logic pullup_90k;
        logic bypass;
        logic timing_adj;
    } tpf_cfg_t;

    // analog switch and reference controls
    typedef struct packed {
        logic [2:0] chan;
        logic       ref_diff;
        logic       xp_drv;
        logic       xm_drv;
        logic       yp_drv;
        logic       ym_drv;
        logic       pen_connect;
        logic       pullup_90k;
    } tpf_ana_t;

    localparam tpf_cfg_t CFG_RESET = '{pullup_90k: 1'b0, bypass: 1'b0,
                                       timing_adj: 1'b0};
    localparam tpf_cmd_t CMD_RESET = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ACQ  = 3'b001,
        ST_CONV = 3'b010,
        ST_WAIT = 3'b011,
        ST_SORT = 3'b100
    } tpf_state_t;

endpackage

// ===== verification/tpf_core_assertions.sv
// port-level assertion checker for the touch panel front end
`timescale 1ns/1ps
`default_nettype none
module tpf_core_checker (
    input wire logic              clk_sys,
    input wire logic              srst,
    input wire logic              link_sclk,
    input wire logic              spi_cs_n,
    input wire logic              spi_sdi,
    input wire logic              spi_sdo,
    input wire logic              spi_sdo_oe_n,
    input wire logic              pen_xplus_low,
    input wire logic              adc_start,
    input wire logic              adc_done,
    input wire logic [11:0]       adc_data,
    input wire tpf_pkg::tpf_ana_t ana,
    input wire logic              pen_touch_irq_n,
    input wire logic              result_invalid
);
    import tpf_pkg::*;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    // armed panel touched long enough to clear the synchroniser
    sequence s_armed_touch;
        (ana.pen_connect && pen_xplus_low) [*5];
    endsequence

    property p_adc_single;
        adc_start |=> !adc_start [*8];
    endproperty
    property p_busy_low;
        adc_start |-> !pen_touch_irq_n;
    endproperty
    property p_armed_touch;
        s_armed_touch |-> !pen_touch_irq_n;
    endproperty
    property p_isolate;
        (ana.xp_drv || ana.xm_drv || ana.yp_drv) |-> !ana.pen_connect;
    endproperty
    property p_y_pair;
        (ana.chan == CHAN_Y && ana.yp_drv) |-> ana.ym_drv && !ana.xp_drv;
    endproperty
    property p_abort_flag;
        $rose(result_invalid) |-> pen_touch_irq_n;
    endproperty
    property p_invalid_clear;
        $fell(result_invalid) |-> ##[0:3] !pen_touch_irq_n;
    endproperty
    property p_cs_release;
        spi_cs_n |-> spi_sdo_oe_n && !spi_sdo;
    endproperty

    // one property per port relation
    a_adc_single: assert property (p_adc_single)
        else $error("converter start repeated too soon");
    a_busy_low: assert property (p_busy_low)
        else $error("pen line high while sampling");
    a_armed_touch: assert property (p_armed_touch)
        else $error("armed touch not signalled");
    a_isolate: assert property (p_isolate)
        else $error("pen detect connected while driving");
    a_y_pair: assert property (p_y_pair)
        else $error("y drivers not paired");
    a_abort_flag: assert property (p_abort_flag)
        else $error("invalid result without pen line high");
    a_invalid_clear: assert property (p_invalid_clear)
        else $error("invalid flag cleared without command");
    a_cs_release: assert property (p_cs_release)
        else $error("output driven while deselected");
endmodule

bind tpf_core tpf_core_checker u_chk (
    .clk_sys(clk_sys), .srst(srst), .link_sclk(link_sclk),
    .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
    .spi_sdo_oe_n(spi_sdo_oe_n), .pen_xplus_low(pen_xplus_low),
    .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data),
    .ana(ana), .pen_touch_irq_n(pen_touch_irq_n),
    .result_invalid(result_invalid)
);
`default_nettype wire

// ===== verification/tpf_core_test.sv
// self-checking bench for the touch panel front end
`timescale 1ns/1ps
`default_nettype none
module tpf_core_test;
    import tpf_pkg::*;
    logic        clk_sys       = 1'b0;
    logic        srst          = 1'b1;
    logic        pen_xplus_low = 1'b0;
    logic        adc_done      = 1'b0;
    logic [11:0] adc_data      = 12'h000;
    wire         link_sclk;
    wire         spi_cs_n;
    wire         spi_sdi;
    logic        spi_sdo;
    logic        spi_sdo_oe_n;
    logic        adc_start;
    logic        pen_touch_irq_n;
    logic        result_invalid;
    tpf_ana_t    ana;
    logic [15:0] rd;
    int          num_errors;
    int          samples_checked;
    int          adc_cnt;
    int          adc_wait;
    int          adc_base;
    logic [11:0] samp [7] = '{12'ha50, 12'h320, 12'h140, 12'h280,
                              12'h1e0, 12'h460, 12'h3c0};

    always #4 clk_sys = ~clk_sys;

    tpf_core dut (
        .clk_sys(clk_sys), .srst(srst), .link_sclk(link_sclk),
        .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
        .spi_sdo_oe_n(spi_sdo_oe_n), .pen_xplus_low(pen_xplus_low),
        .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data),
        .ana(ana), .pen_touch_irq_n(pen_touch_irq_n),
        .result_invalid(result_invalid)
    );
    tpf_host host (
        .link_sclk(link_sclk), .spi_cs_n(spi_cs_n),
        .spi_sdi(spi_sdi), .spi_sdo(spi_sdo)
    );

    // converter stand-in: answers each start ten cycles later
    always @(posedge clk_sys)
    begin
        adc_done <= 1'b0;
        if (adc_start)
            adc_wait <= 10;
        else if (adc_wait > 0)
            adc_wait <= adc_wait - 1;
        if (adc_wait == 1)
        begin
            adc_done <= 1'b1;
            adc_data <= samp[(adc_cnt - adc_base) % 7];
            adc_cnt  <= adc_cnt + 1;
        end
    end

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic setup(input logic [7:0] cmd);
        host.xfer({cmd, 8'h00}, 16, rd);
        ticks(20);
    endtask
    // command bits plus three acquisition clocks, then pause
    task automatic start(input logic [7:0] cmd);
        adc_base <= adc_cnt;
        host.xfer({cmd, 8'h00}, 11, rd);
        ticks(2);
    endtask
    // bounded wait for end of conversion, then finish the frame
    task automatic finish(input int rest);
        int k;
        k = 0;
        while (pen_touch_irq_n !== 1'b1 && k < 4000)
        begin
            @(posedge clk_sys);
            k++;
        end
        chk_bit(k < 4000, 1'b1);
        ticks(3);
        host.xfer(16'h0000, rest, rd);
        ticks(3);
    endtask
    task automatic touch(input logic exp_irq_n);
        pen_xplus_low <= 1'b1;
        ticks(8);
        chk_bit(pen_touch_irq_n, exp_irq_n);
        pen_xplus_low <= 1'b0;
        ticks(8);
    endtask
    task automatic conclude;
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        ticks(5);
        chk_val({6'h00, ana}, 16'h0006);
        touch(1'b0);
        setup(8'ha8);
        chk_bit(ana.pullup_90k, 1'b1);
        setup(8'ha0);
        chk_bit(ana.pullup_90k, 1'b0);
        start(8'hd0);
        chk_val({6'h00, ana}, 16'h02f0);
        finish(5);
        chk_val(16'(adc_cnt - adc_base), 16'h0007);
        chk_val({6'h00, ana}, 16'h0006);
        touch(1'b0);
        host.xfer({8'ha0, 8'h00}, 16, rd);
        chk_val({8'h00, rd[7:0]}, 16'h0019);
        start(8'h91);
        chk_val({6'h00, ana}, 16'h00cc);
        finish(5);
        chk_val({6'h00, ana}, 16'h00cc);
        touch(1'b1);
        setup(8'ha6);
        start(8'h80);
        finish(5);
        chk_val(16'(adc_cnt - adc_base), 16'h0001);
        chk_val({6'h00, ana}, 16'h0006);
        host.xfer({8'ha6, 8'h00}, 16, rd);
        chk_val({8'h00, rd[7:0]}, 16'h00a5);
        setup(8'ha2);
        start(8'hd0);
        ticks(20);
        host.xfer(16'h0000, 1, rd);
        ticks(10);
        chk_bit(result_invalid, 1'b1);
        chk_bit(pen_touch_irq_n, 1'b1);
        host.xfer(16'h0000, 4, rd);
        host.release_bus();
        ticks(4);
        chk_bit(spi_sdo_oe_n, 1'b1);
        start(8'h88);
        finish(1);
        chk_bit(result_invalid, 1'b0);
        host.xfer({8'ha2, 8'h00}, 12, rd);
        chk_val({12'h000, rd[3:0]}, 16'h0003);
        conclude();
    end

    // watchdog against a hang
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        num_errors++;
        conclude();
    end
endmodule
`default_nettype wire

// ===== verification/tpf_host.sv
// host model: serial master in clock mode zero
`timescale 1ns/1ps
`default_nettype none
module tpf_host (
    output var  logic link_sclk,
    output var  logic spi_cs_n,
    output var  logic spi_sdi,
    input  wire logic spi_sdo
);
    // link idles low, device deselected
    initial
    begin
        link_sclk = 1'b0;
        spi_cs_n  = 1'b1;
        spi_sdi   = 1'b0;
    end

    // shift n bits msb first; clock stands still afterwards
    task automatic xfer(input logic [15:0] out, input int n,
                        output logic [15:0] in);
        in = 16'h0000;
        #3.1;
        spi_cs_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            spi_sdi = out[15 - i];
            #80;
            link_sclk = 1'b1;
            in = {in[14:0], spi_sdo};
            #80;
            link_sclk = 1'b0;
        end
    endtask

    // deselect; released data line shows no stale level
    task automatic release_bus;
        #80;
        spi_cs_n = 1'b1;
        spi_sdi  = ~spi_sdi;
    endtask
endmodule
`default_nettype wire
